// ===== hdl/rsc_defs.vh
// Constants for the rheostat serial command decoder.
// Included by the store and top design files, not the synchroniser; definitions only.
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// Frame layout
`define RSC_FRAME_BITS 16
`define RSC_CMD_HI 13
`define RSC_CMD_LO 10
`define RSC_DATA_BITS 10
`define RSC_READ_BITS 10

// Command codes
`define RSC_CMD_NOP 4'h0
`define RSC_CMD_WR_WIPER 4'h1
`define RSC_CMD_RD_WIPER 4'h2
`define RSC_CMD_STORE 4'h3
`define RSC_CMD_SW_RESET 4'h4
`define RSC_CMD_RD_STORE 4'h5
`define RSC_CMD_RD_LAST 4'h6
`define RSC_CMD_WR_CTRL 4'h7
`define RSC_CMD_RD_CTRL 4'h8
`define RSC_CMD_SHUTDOWN 4'h9

// Control flag positions and reset value
`define RSC_CTL_PROG_EN 0
`define RSC_CTL_UNLOCK 1
`define RSC_CTL_CAL_DIS 2
`define RSC_CTL_SUCCESS 3
`define RSC_CTL_RESET 4'h0

// Store geometry
`define RSC_STORE_DEPTH 50
`define RSC_FIRST_LOC 6'h01
`define RSC_MIDSCALE 10'h200

// Store busy time
`define RSC_CLK_HZ 10000000
`define RSC_STORE_MS 350
`define RSC_STORE_CYCLES ((`RSC_CLK_HZ / 1000) * `RSC_STORE_MS)

`endif

// ===== hdl/rsc_sync2.v
// Two-flop synchroniser for one pin input.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module rsc_sync2 #(
	parameter RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Pin and result
	input wire pin_in,
	output reg sync_out
);
	reg meta_r;

	always @(posedge clock) begin
		if (!resetn) begin
			meta_r <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_r <= pin_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/rsc_otp_store.v
// One-time-programmable wiper store: array, write pointer, busy timer.
// Assumes store requests come only while not busy.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.vh"
module rsc_otp_store #(
	parameter STORE_CYCLES = `RSC_STORE_CYCLES
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Store request
	input wire store_req,
	input wire [9:0] store_data,
	// Read port
	input wire [5:0] rd_loc,
	output wire [9:0] rd_data,
	// Status
	output reg [5:0] last_loc_r = 6'h00,
	output wire [9:0] last_val,
	output reg busy_r,
	output reg done_r
);
	reg [9:0] mem_r [0:63];
	reg [31:0] timer_r;
	reg [9:0] pend_r;
	wire full;

	assign full = (last_loc_r == 6'd`RSC_STORE_DEPTH);
	assign rd_data = (rd_loc == 6'h00) ? 10'h000 : mem_r[rd_loc];
	assign last_val = (last_loc_r == 6'h00) ? `RSC_MIDSCALE :
		mem_r[last_loc_r];

	// Fuse content survives soft reset, so the array has no reset
	always @(posedge clock) begin
		if (busy_r && timer_r == 32'h0000_0001)
			mem_r[last_loc_r + 6'h01] <= pend_r; // see [RULE_24]
	end

	always @(posedge clock) begin
		// Pointer is fuse state: kept across soft reset
		if (!resetn) begin
			busy_r <= 1'b0;
			timer_r <= 32'h0000_0000;
			pend_r <= 10'h000;
			done_r <= 1'b0;
		end else if (busy_r) begin
			timer_r <= timer_r - 32'h0000_0001; // see [RULE_11]
			if (timer_r == 32'h0000_0001) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
				last_loc_r <= last_loc_r + 6'h01; // see [RULE_24]
			end
		end else if (store_req && !full) begin
			busy_r <= 1'b1;
			done_r <= 1'b0;
			pend_r <= store_data;
			timer_r <= STORE_CYCLES;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/rsc_top.v
// Serial command decoder of a digital rheostat.
// Assumes sclk, frame_sel_n and din come from an outside master.
//
// Overview of operation
// [RULE_01] Frame is 16 bits: two zero bits, command 13:10, data 9:0.
// [RULE_02] Bits arrive most significant first, starting at bit 15.
// [RULE_03] Narrow variant ignores two low wiper bits; readback meaningless.
// [RULE_04] Master holds frame select low until all bits are shifted.
// [RULE_05] Received word executes only when frame select returns high.
// [RULE_06] Clocks counted in multiples of 16; master sends whole multiples.
// [RULE_07] Serial clock may stop while frame select is high.
// [RULE_08] Code 1 loads wiper register; code 0 does nothing.
// [RULE_09] Code 2 selects wiper register for readback.
// [RULE_10] Code 3 stores wiper into next store location.
// [RULE_11] A store lasts 350 ms; all changes ignored meanwhile.
// [RULE_12] Code 4 reloads wiper from last stored value.
// [RULE_13] Code 5 reads store location given by data bits 5:0.
// [RULE_14] Code 6 reads address of last programmed store location.
// [RULE_15] Code 7 writes control bits 2:0; success flag not writable.
// [RULE_16] Code 8 selects control register for readback.
// [RULE_17] Code 9 enters shutdown on data bit 0 set, leaves on clear.
// [RULE_18] Control bit 0 enables store programming; resets to 0.
// [RULE_19] Control bit 1 resets 0, freezing wiper; 1 permits writes.
// [RULE_20] Control bit 2 resets 0; 1 disables tolerance calibration.
// [RULE_21] Control bit 3 is read-only success flag, set after store.
// [RULE_22] After a store, reset loads the stored value into the wiper.
// [RULE_23] Read data leaves on the last ten clocks of next frame.
// [RULE_24] First store goes to location 1, then increments until full.
// [RULE_25] Frame ended before sixteenth clock is discarded.
// [RULE_26] Software reset works even while the wiper is protected.
// [RULE_27] Store needs program enable; wiper write needs unlock bit.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.vh"
module rsc_top #(
	parameter NARROW = 1'b0,
	parameter STORE_CYCLES = `RSC_STORE_CYCLES
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Serial pins
	input wire sclk,
	input wire frame_sel_n,
	input wire din,
	output wire serial_out_o,
	output wire serial_out_oe_n,
	// Device state
	output reg [9:0] wiper_position_register,
	output wire [3:0] control_flags,
	output reg shutdown_r,
	output wire store_busy
);
	wire sclk_s;
	wire sel_n_s;
	wire din_s;
	reg sclk_d_r;
	reg sel_n_d_r;
	reg [15:0] shift_r;
	reg [4:0] bit_cnt_r;
	reg whole_r;
	reg [15:0] out_r;
	reg [15:0] out_nxt;
	reg [2:0] ctl_r;
	reg init_r;
	reg [5:0] rd_loc_r;
	reg store_req_r;
	wire sclk_fall;
	wire sel_rise;
	wire sel_fall;
	wire [3:0] cmd;
	wire [9:0] dat;
	wire [9:0] wr_val;
	wire [9:0] rd_data;
	wire [9:0] last_val;
	wire [5:0] last_loc;
	wire store_done;
	wire exec;
	wire [5:0] rd_loc;
	localparam [3:0] CTL_RST = `RSC_CTL_RESET;

	rsc_sync2 #(.RESET_VAL(1'b0)) u_sclk (
		.clock(clock),
		.resetn(resetn),
		.pin_in(sclk),
		.sync_out(sclk_s)
	);
	rsc_sync2 #(.RESET_VAL(1'b1)) u_sel (
		.clock(clock),
		.resetn(resetn),
		.pin_in(frame_sel_n),
		.sync_out(sel_n_s)
	);
	rsc_sync2 #(.RESET_VAL(1'b0)) u_din (
		.clock(clock),
		.resetn(resetn),
		.pin_in(din),
		.sync_out(din_s)
	);

	rsc_otp_store #(.STORE_CYCLES(STORE_CYCLES)) u_store (
		.clock(clock),
		.resetn(resetn),
		.store_req(store_req_r),
		.store_data(wiper_position_register),
		.rd_loc(rd_loc),
		.rd_data(rd_data),
		.last_loc_r(last_loc),
		.last_val(last_val),
		.busy_r(store_busy),
		.done_r(store_done)
	);

	assign sclk_fall = sclk_d_r && !sclk_s;
	assign sel_rise = !sel_n_d_r && sel_n_s;
	assign sel_fall = sel_n_d_r && !sel_n_s;
	assign cmd = shift_r[`RSC_CMD_HI:`RSC_CMD_LO]; // see [RULE_01]
	assign dat = shift_r[9:0];
	// Read port follows the frame being executed
	assign rd_loc = (exec && cmd == `RSC_CMD_RD_STORE) ? dat[5:0] : rd_loc_r;
	// Narrow variant drops two low wiper bits
	assign wr_val = NARROW ? {dat[9:2], 2'b00} : dat; // see [RULE_03]
	// Execute only whole frames, never during a store
	assign exec = sel_rise && whole_r && !store_busy; // see [RULE_05]
	assign control_flags = {store_done, ctl_r}; // see [RULE_21]
	// Open drain: pull low when the bit is zero
	assign serial_out_o = 1'b0;
	assign serial_out_oe_n = sel_n_s | out_r[15]; // see [RULE_23]

	// Edge detect on synchronised pins; sclk idle is harmless
	always @(posedge clock) begin
		if (!resetn) begin
			sclk_d_r <= 1'b0;
			sel_n_d_r <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s; // see [RULE_07]
			sel_n_d_r <= sel_n_s;
		end
	end

	// Shift in on falling sclk, MSB first, count modulo 16
	always @(posedge clock) begin
		if (!resetn) begin
			shift_r <= 16'h0000;
			bit_cnt_r <= 5'h00;
			whole_r <= 1'b0;
		end else if (sel_fall) begin
			bit_cnt_r <= 5'h00;
			whole_r <= 1'b0;
		end else if (!sel_n_s && sclk_fall) begin
			shift_r <= {shift_r[14:0], din_s}; // see [RULE_02]
			if (bit_cnt_r == 5'd15) begin
				bit_cnt_r <= 5'h00; // see [RULE_06]
				whole_r <= 1'b1;
			end else begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
				whole_r <= 1'b0; // see [RULE_25]
			end
		end
	end

	// Readback word: shifts out on each falling sclk inside a frame
	always @* begin
		out_nxt = out_r;
		if (exec) begin
			out_nxt = shift_r;
			if (cmd == `RSC_CMD_RD_WIPER)
				out_nxt = {6'h00, wiper_position_register}; // see [RULE_09]
			else if (cmd == `RSC_CMD_RD_STORE)
				out_nxt = {6'h00, rd_data}; // see [RULE_13]
			else if (cmd == `RSC_CMD_RD_LAST)
				out_nxt = {10'h000, last_loc}; // see [RULE_14]
			else if (cmd == `RSC_CMD_RD_CTRL)
				out_nxt = {12'h000, control_flags}; // see [RULE_16]
		end else if (!sel_n_s && sclk_fall) begin
			out_nxt = {out_r[14:0], 1'b1};
		end
	end

	always @(posedge clock) begin
		if (!resetn)
			out_r <= 16'hFFFF;
		else
			out_r <= out_nxt;
	end

	// Memory location latch for the store read port
	always @(posedge clock) begin
		if (!resetn)
			rd_loc_r <= 6'h00;
		else if (exec && cmd == `RSC_CMD_RD_STORE)
			rd_loc_r <= dat[5:0]; // see [RULE_13]
	end

	// Command execution and control flags
	always @(posedge clock) begin
		if (!resetn) begin
			ctl_r <= CTL_RST[2:0]; // see [RULE_18]
			shutdown_r <= 1'b0;
			store_req_r <= 1'b0;
			init_r <= 1'b1;
			wiper_position_register <= `RSC_MIDSCALE;
		end else begin
			store_req_r <= 1'b0;
			if (init_r) begin
				init_r <= 1'b0;
				wiper_position_register <= last_val; // see [RULE_22]
			end else if (exec) begin // see [RULE_11]
				case (cmd)
				`RSC_CMD_WR_WIPER: begin
					if (ctl_r[`RSC_CTL_UNLOCK]) // see [RULE_19]
						wiper_position_register <= wr_val; // see [RULE_08]
				end
				`RSC_CMD_STORE: begin
					if (ctl_r[`RSC_CTL_PROG_EN]) // see [RULE_27]
						store_req_r <= 1'b1; // see [RULE_10]
				end
				`RSC_CMD_SW_RESET: begin
					wiper_position_register <= last_val; // see [RULE_12] [RULE_26]
				end
				`RSC_CMD_WR_CTRL: begin
					ctl_r <= dat[2:0]; // see [RULE_15] [RULE_20]
				end
				`RSC_CMD_SHUTDOWN: begin
					shutdown_r <= dat[0]; // see [RULE_17]
				end
				default: begin
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/rsc_spi_master.sv
// Serial bus master model driving the decoder pins.
// Assumes an open-drain return line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module rsc_spi_master (
	// Clock
	input wire logic clock,
	// Serial pins
	output var logic sclk,
	output var logic frame_sel_n,
	output var logic din,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n
);
	logic sdo_pin;
	assign sdo_pin = serial_out_oe_n ? 1'b1 : serial_out_o;
	initial begin
		sclk = 1'b0;
		frame_sel_n = 1'b1;
		din = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Sends low n bits of w; r keeps the last 16 bits seen
	task automatic xfer(input logic [31:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		frame_sel_n = 1'b0;
		tick(4);
		for (int i = n - 1; i >= 0; i--) begin
			din = w[i];
			sclk = 1'b1;
			tick(4);
			// Sample before the falling edge advances the output
			r = {r[14:0], sdo_pin};
			sclk = 1'b0;
			tick(4);
		end
		frame_sel_n = 1'b1;
		din = ~din;
		tick(8);
	endtask
endmodule
`default_nettype wire

// ===== verif/rsc_top_monitor.sv
// Port checker for the serial command decoder.
// Bound into rsc_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module rsc_top_monitor #(
	parameter NARROW = 1'b0,
	parameter STORE_CYCLES = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Serial pins
	input wire logic sclk,
	input wire logic frame_sel_n,
	input wire logic din,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n,
	// Device state
	input wire logic [9:0] wiper_position_register,
	input wire logic [3:0] control_flags,
	input wire logic shutdown_r,
	input wire logic store_busy
);
	logic fs_r;
	logic [3:0] age_r;
	int busy_cnt_r;
	// Cycles since frame select rose
	always @(posedge clock) begin
		fs_r <= frame_sel_n;
		if (!resetn || (frame_sel_n && !fs_r))
			age_r <= 4'h0;
		else if (age_r != 4'hf)
			age_r <= age_r + 4'h1;
		busy_cnt_r <= (resetn && store_busy) ? busy_cnt_r + 1 : 0;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_wiper_cause: assert property (
		$changed(wiper_position_register) && $past(resetn) |-> age_r <= 4'h6)
		else $error("wiper moved outside a frame end");
	chk_flags_cause: assert property (
		$changed(control_flags[2:0]) && $past(resetn) |-> age_r <= 4'h6)
		else $error("flags moved outside a frame end");
	chk_shutdown_cause: assert property (
		$changed(shutdown_r) && $past(resetn) |-> age_r <= 4'h6)
		else $error("shutdown moved outside a frame end");
	chk_store_enable: assert property (
		$rose(store_busy) |-> control_flags[0] && age_r <= 4'h6)
		else $error("store began without enable");
	chk_busy_length: assert property (
		$fell(store_busy) |-> busy_cnt_r >= STORE_CYCLES &&
		busy_cnt_r <= STORE_CYCLES + 1)
		else $error("store busy time wrong");
	chk_busy_freeze: assert property (
		store_busy && $past(store_busy) |-> $stable(wiper_position_register)
		&& $stable(control_flags[2:0]))
		else $error("state changed while busy");
	chk_success_flag: assert property (
		$rose(control_flags[3]) |-> !store_busy && $past(store_busy, 2))
		else $error("success flag without store end");
	chk_drain_low: assert property (
		!serial_out_oe_n |-> !serial_out_o)
		else $error("open drain drove high");
	chk_drain_idle: assert property (
		frame_sel_n && $past(frame_sel_n) && $past(frame_sel_n, 2)
		|-> serial_out_oe_n)
		else $error("output driven outside a frame");
	chk_reset_state: assert property (
		disable iff (1'b0) !resetn |=> control_flags == 4'h0 &&
		wiper_position_register == 10'h200 && !shutdown_r && !store_busy)
		else $error("reset state wrong");
	cov_store: cover property ($fell(store_busy));
	cov_shutdown: cover property ($rose(shutdown_r));
	cov_readback: cover property (!serial_out_oe_n);
endmodule
bind rsc_top rsc_top_monitor #(.NARROW(NARROW), .STORE_CYCLES(STORE_CYCLES))
	i_rsc_top_monitor (.clock(clock), .resetn(resetn), .sclk(sclk),
	.frame_sel_n(frame_sel_n), .din(din), .serial_out_o(serial_out_o),
	.serial_out_oe_n(serial_out_oe_n), .shutdown_r(shutdown_r),
	.wiper_position_register(wiper_position_register),
	.control_flags(control_flags), .store_busy(store_busy));
`default_nettype wire

// ===== verif/rheostat_serial_command_decoder_bench.sv
// Self-checking bench for the serial command decoder.
// Pins driven by the master model; store time shortened.
`timescale 1ns/1ps
`default_nettype none
module rheostat_serial_command_decoder_bench;
	logic clock;
	logic resetn;
	wire sclk;
	wire frame_sel_n;
	wire din;
	wire so;
	wire so_oe_n;
	wire [9:0] wiper;
	wire [9:0] wiper_n;
	wire [3:0] flags;
	wire shutdown;
	wire busy;
	logic [15:0] rd;
	int miscompares = 0;
	int samples_checked = 0;
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	rsc_top #(.STORE_CYCLES(300)) i_rsc_top (.clock(clock), .resetn(resetn),
		.sclk(sclk), .frame_sel_n(frame_sel_n), .din(din),
		.serial_out_o(so), .serial_out_oe_n(so_oe_n),
		.wiper_position_register(wiper), .control_flags(flags),
		.shutdown_r(shutdown), .store_busy(busy));
	// Narrow variant listens to the same frames
	rsc_top #(.NARROW(1'b1), .STORE_CYCLES(300)) i_rsc_top_narrow (
		.clock(clock), .resetn(resetn),
		.sclk(sclk), .frame_sel_n(frame_sel_n), .din(din),
		.serial_out_o(), .serial_out_oe_n(),
		.wiper_position_register(wiper_n), .control_flags(),
		.shutdown_r(), .store_busy());
	rsc_spi_master i_rsc_spi_master (.clock(clock), .sclk(sclk),
		.frame_sel_n(frame_sel_n), .din(din), .serial_out_o(so),
		.serial_out_oe_n(so_oe_n));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] fw(input logic [3:0] c,
		input logic [9:0] d);
		return {2'b00, c, d};
	endfunction
	task automatic send(input logic [15:0] w);
		i_rsc_spi_master.xfer({16'h0000, w}, 16, rd);
	endtask
	task automatic final_report;
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_reset;
		cmp(16'(wiper), 16'h0200);
		cmp(16'(flags), 16'h0000);
		cmp(16'({shutdown, busy}), 16'h0000);
	endtask
	task automatic t_write;
		send(fw(4'h1, 10'h155));
		cmp(16'(wiper), 16'h0200);
		send(fw(4'h3, 10'h000));
		cmp(16'(busy), 16'h0000);
		send(fw(4'h7, 10'h3ff));
		cmp(16'(flags), 16'h0007);
		send(fw(4'h1, 10'h155));
		send(fw(4'h0, 10'h3ff));
		cmp(16'(wiper), 16'h0155);
		cmp(16'(wiper_n), 16'h0154);
		i_rsc_spi_master.xfer(32'(fw(4'h1, 10'h0aa) >> 4), 12, rd);
		cmp(16'(wiper), 16'h0155);
		i_rsc_spi_master.xfer({fw(4'h0, 10'h0), fw(4'h1, 10'h2aa)}, 32, rd);
		cmp(16'(wiper), 16'h02aa);
	endtask
	task automatic t_read;
		send(fw(4'h2, 10'h0));
		send(fw(4'h0, 10'h0));
		cmp(16'(rd[9:0]), 16'h02aa);
		send(fw(4'h8, 10'h0));
		send(fw(4'h0, 10'h0));
		cmp(16'(rd[9:0]), 16'h0007);
	endtask
	task automatic t_store;
		send(fw(4'h3, 10'h0));
		cmp(16'(busy), 16'h0001);
		send(fw(4'h1, 10'h011));
		cmp(16'(wiper), 16'h02aa);
		for (int k = 0; k < 400 && busy !== 1'b0; k++)
			i_rsc_spi_master.tick(1);
		cmp(16'(flags), 16'h000f);
		send(fw(4'h6, 10'h0));
		send(fw(4'h0, 10'h0));
		cmp(16'(rd[5:0]), 16'h0001);
		send(fw(4'h5, 10'h001));
		send(fw(4'h0, 10'h0));
		cmp(16'(rd[9:0]), 16'h02aa);
		send(fw(4'h1, 10'h0f0));
		cmp(16'(wiper), 16'h00f0);
		send(fw(4'h7, 10'h001));
		send(fw(4'h4, 10'h0));
		cmp(16'(wiper), 16'h02aa);
		resetn = 1'b0;
		i_rsc_spi_master.tick(3);
		resetn = 1'b1;
		i_rsc_spi_master.tick(4);
		cmp(16'(wiper), 16'h02aa);
		cmp(16'(flags), 16'h0000);
	endtask
	task automatic t_shutdown;
		send(fw(4'h9, 10'h001));
		cmp(16'(shutdown), 16'h0001);
		send(fw(4'h9, 10'h000));
		cmp(16'(shutdown), 16'h0000);
	endtask
	initial begin
		#2_000_000;
		miscompares++;
		final_report;
	end
	initial begin
		resetn = 1'b0;
		i_rsc_spi_master.tick(12);
		resetn = 1'b1;
		i_rsc_spi_master.tick(4);
		t_reset;
		t_write;
		t_read;
		t_shutdown;
		t_store;
		final_report;
	end
endmodule
`default_nettype wire
